// ### lsf_pkg.sv
// What this block does
// - Bit 5 of the status flags follows the synchronised fail-safe pin level.
// - Bit 4 reads 1 after memory programming completes, 0 before or during.
// - Bit 3 reads 1 while supply is below the ADC threshold, else 0.
// - Bit 2 is set when an ADC conversion result becomes available.
// - Reading the general ADC result register clears the conversion-done flag.
// - Bit 1 reads 1 after an on-demand diagnostics run finishes, else 0.
// - Bit 0 shows the memory CRC check result, 1 for failure.
// - Supply ADC result has its own read-only 8-bit register.
// - General ADC result has its own read-only register resetting to zero.
// - Low diagnostic register bit n flags an on-demand fault on channel n.
// - High diagnostic register bits 3..0 flag channels 11..8; bits 7..4 zero.
// - A channel fault bit covers open, short and single-LED short faults.
// - CRC reference resets to B3h, or 09h on the alternate silicon version.
// - Programming starts only in programming mode; its end sets the done flag.
package lsf_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int CH_NUM = 12;
    localparam int CH_LO = 8;
    // Printed offsets are register indices; byte address is four times the index
    localparam logic [7:0] IDX_FLAGS_B = 8'h71;
    localparam logic [7:0] IDX_SUPPLY_ADC = 8'h72;
    localparam logic [7:0] IDX_ADC_RESULT = 8'h73;
    localparam logic [7:0] IDX_DIAG_LO = 8'h74;
    localparam logic [7:0] IDX_DIAG_HI = 8'h75;
    localparam logic [7:0] IDX_CRC_REF = 8'h77;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h80;
    localparam logic [7:0] IDX_IRQ_CLEAR = 8'h81;
    localparam logic [7:0] IDX_IRQ_ENABLE = 8'h82;
    // Status flag bit positions
    localparam int BIT_FAILSAFE = 5;
    localparam int BIT_PROG_DONE = 4;
    localparam int BIT_SUPPLY_LOW = 3;
    localparam int BIT_CONV_DONE = 2;
    localparam int BIT_DIAG_DONE = 1;
    localparam int BIT_CRC_FAIL = 0;
    // Interrupt layout
    localparam int IRQ_W = 5;
    localparam int IRQ_CONV = 0;
    localparam int IRQ_DIAG = 1;
    localparam int IRQ_PROG = 2;
    localparam int IRQ_SUPPLY = 3;
    localparam int IRQ_CRC = 4;
    // Reset values
    localparam logic [7:0] RST_CRC_REF = 8'hB3;
    localparam logic [7:0] RST_CRC_REF_ALT = 8'h09;
    localparam logic [7:0] RST_ADC = 8'h00;
    localparam logic [IRQ_W-1:0] RST_IRQ = 5'h00;

    function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction
endpackage

// ### lsf_status_flags.sv
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module lsf_status_flags
    import lsf_pkg::*;
#(
    parameter bit ALT_SILICON = 1'b0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic failsafe_input_pin,
    input wire logic nvm_program_mode,
    input wire logic nvm_program_start,
    input wire logic nvm_program_complete,
    input wire logic supply_below_threshold,
    input wire logic supply_adc_valid,
    input wire logic [7:0] supply_adc_data,
    input wire logic adc_conv_valid,
    input wire logic [7:0] adc_conv_data,
    input wire logic diag_start,
    input wire logic diag_finish,
    input wire logic [CH_NUM-1:0] diag_open,
    input wire logic [CH_NUM-1:0] diag_short,
    input wire logic [CH_NUM-1:0] diag_single_short,
    input wire logic crc_check_valid,
    input wire logic crc_check_fail,
    input wire logic crc_ref_load,
    input wire logic [7:0] crc_ref_data,
    output logic irq
);
    localparam logic [7:0] CRC_REF_INIT = ALT_SILICON ? RST_CRC_REF_ALT : RST_CRC_REF;

    logic failsafe_meta_q, failsafe_sync_q;
    logic prog_busy_q, prog_busy_d, prog_done_q, prog_done_d;
    logic supply_low_q, supply_low_d;
    logic conv_done_q, conv_done_d;
    logic diag_done_q, diag_done_d;
    logic crc_fail_q, crc_fail_d;
    logic [7:0] supply_adc_q, supply_adc_d;
    logic [7:0] adc_result_q, adc_result_d;
    logic [CH_NUM-1:0] diag_fault_q, diag_fault_d;
    logic [7:0] crc_ref_q, crc_ref_d;
    logic [IRQ_W-1:0] irq_status_q, irq_status_d, irq_en_q, irq_en_d, irq_evt;
    logic irq_q, irq_d;
    logic [DATA_W-1:0] prdata_q, prdata_d;
    logic pready_q, pready_d, pslverr_q, pslverr_d;
    logic access, fire, rd_fire, wr_fire, adc_read_clear, prog_accept;
    logic [7:0] flags_b;
    logic [DATA_W-1:0] rd_mux;
    logic rd_hit;

    // Fail-safe pin comes from outside, two flops before use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            failsafe_meta_q <= 1'b0;
            failsafe_sync_q <= 1'b0;
        end else begin
            failsafe_meta_q <= failsafe_input_pin;
            failsafe_sync_q <= failsafe_meta_q;
        end
    end

    // APB: one wait state, so the read mux is registered
    assign access = psel && penable;
    assign fire = access && pready_q;
    assign rd_fire = fire && !pwrite;
    assign wr_fire = fire && pwrite;
    assign adc_read_clear = rd_fire && (paddr == reg_addr(IDX_ADC_RESULT));
    assign prog_accept = nvm_program_start && nvm_program_mode;

    always_comb begin
        flags_b = 8'h00;
        flags_b[BIT_FAILSAFE] = failsafe_sync_q;
        flags_b[BIT_PROG_DONE] = prog_done_q;
        flags_b[BIT_SUPPLY_LOW] = supply_low_q;
        flags_b[BIT_CONV_DONE] = conv_done_q;
        flags_b[BIT_DIAG_DONE] = diag_done_q;
        flags_b[BIT_CRC_FAIL] = crc_fail_q;
    end

    always_comb begin
        rd_mux = '0;
        rd_hit = 1'b1;
        unique case (paddr)
            reg_addr(IDX_FLAGS_B): rd_mux[7:0] = flags_b;
            reg_addr(IDX_SUPPLY_ADC): rd_mux[7:0] = supply_adc_q;
            reg_addr(IDX_ADC_RESULT): rd_mux[7:0] = adc_result_q;
            reg_addr(IDX_DIAG_LO): rd_mux[7:0] = diag_fault_q[CH_LO-1:0];
            reg_addr(IDX_DIAG_HI): rd_mux[3:0] = diag_fault_q[CH_NUM-1:CH_LO];
            reg_addr(IDX_CRC_REF): rd_mux[7:0] = crc_ref_q;
            reg_addr(IDX_IRQ_STATUS): rd_mux[IRQ_W-1:0] = irq_status_q;
            reg_addr(IDX_IRQ_CLEAR): rd_mux = '0;
            reg_addr(IDX_IRQ_ENABLE): rd_mux[IRQ_W-1:0] = irq_en_q;
            default: rd_hit = 1'b0;
        endcase
    end

    always_comb begin
        pready_d = access && !pready_q;
        prdata_d = '0;
        pslverr_d = 1'b0;
        if (access && !pready_q) begin
            prdata_d = pwrite ? '0 : rd_mux;
            pslverr_d = !rd_hit;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            prdata_q <= '0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= pready_d;
            prdata_q <= prdata_d;
            pslverr_q <= pslverr_d;
        end
    end

    // Flag bank: hardware events and the ADC result read move it; bus writes never reach it
    always_comb begin
        prog_busy_d = prog_busy_q;
        prog_done_d = prog_done_q;
        if (prog_accept && !prog_busy_q) begin
            prog_busy_d = 1'b1;
            prog_done_d = 1'b0;
        end
        if (nvm_program_complete && prog_busy_q) begin
            prog_busy_d = 1'b0;
            prog_done_d = 1'b1;
        end
        supply_low_d = supply_below_threshold;
        supply_adc_d = supply_adc_valid ? supply_adc_data : supply_adc_q;
        adc_result_d = adc_conv_valid ? adc_conv_data : adc_result_q;
        // A new result in the clearing read's cycle keeps the flag set
        conv_done_d = adc_conv_valid || (conv_done_q && !adc_read_clear);
        diag_done_d = diag_done_q;
        diag_fault_d = diag_fault_q;
        if (diag_start) begin
            diag_done_d = 1'b0;
            diag_fault_d = '0;
        end
        if (diag_finish) begin
            diag_done_d = 1'b1;
            diag_fault_d = diag_open | diag_short | diag_single_short;
        end
        crc_fail_d = crc_check_valid ? crc_check_fail : crc_fail_q;
        crc_ref_d = crc_ref_load ? crc_ref_data : crc_ref_q;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prog_busy_q <= 1'b0;
            prog_done_q <= 1'b0;
            supply_low_q <= 1'b0;
            supply_adc_q <= RST_ADC;
            adc_result_q <= RST_ADC;
            conv_done_q <= 1'b0;
            diag_done_q <= 1'b0;
            diag_fault_q <= '0;
            crc_fail_q <= 1'b0;
            crc_ref_q <= CRC_REF_INIT;
        end else begin
            prog_busy_q <= prog_busy_d;
            prog_done_q <= prog_done_d;
            supply_low_q <= supply_low_d;
            supply_adc_q <= supply_adc_d;
            adc_result_q <= adc_result_d;
            conv_done_q <= conv_done_d;
            diag_done_q <= diag_done_d;
            diag_fault_q <= diag_fault_d;
            crc_fail_q <= crc_fail_d;
            crc_ref_q <= crc_ref_d;
        end
    end

    // Interrupts: sticky status, write-one-to-clear, set beats clear
    always_comb begin
        irq_evt = '0;
        irq_evt[IRQ_CONV] = conv_done_d && !conv_done_q;
        irq_evt[IRQ_DIAG] = diag_done_d && !diag_done_q;
        irq_evt[IRQ_PROG] = prog_done_d && !prog_done_q;
        irq_evt[IRQ_SUPPLY] = supply_low_d && !supply_low_q;
        irq_evt[IRQ_CRC] = crc_fail_d && !crc_fail_q;
        irq_status_d = irq_status_q;
        irq_en_d = irq_en_q;
        if (wr_fire && pstrb[0] && paddr == reg_addr(IDX_IRQ_CLEAR)) begin
            irq_status_d = irq_status_q & ~pwdata[IRQ_W-1:0];
        end
        if (wr_fire && pstrb[0] && paddr == reg_addr(IDX_IRQ_ENABLE)) begin
            irq_en_d = pwdata[IRQ_W-1:0];
        end
        irq_status_d = irq_status_d | irq_evt;
        irq_d = |(irq_status_q & irq_en_q);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status_q <= RST_IRQ;
            irq_en_q <= RST_IRQ;
            irq_q <= 1'b0;
        end else begin
            irq_status_q <= irq_status_d;
            irq_en_q <= irq_en_d;
            irq_q <= irq_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign irq = irq_q;

    logic [CH_NUM-1:0] diag_any;
    logic [CH_NUM-CH_LO-1:0] diag_hi_now;
    logic [IRQ_W-1:0] clr_bits;
    logic irq_pending;
    assign diag_any = diag_open | diag_short | diag_single_short;
    assign diag_hi_now = diag_fault_q[CH_NUM-1:CH_LO];
    assign clr_bits = pwdata[IRQ_W-1:0];
    assign irq_pending = |(irq_status_q & irq_en_q);

    logic wr_bank;
    assign wr_bank = wr_fire && paddr >= reg_addr(IDX_FLAGS_B) && paddr <= reg_addr(IDX_CRC_REF);

    sequence s_setup_access;
        psel && penable && !pready;
    endsequence

    sequence s_read_of_adc;
        psel && penable && pready && !pwrite && paddr == reg_addr(IDX_ADC_RESULT);
    endsequence

    property p_apb_answer;
        @(posedge pclk) disable iff (!presetn)
        s_setup_access |=> pready ##1 !pready;
    endproperty
    a_apb_answer: assert property (p_apb_answer) else $error("APB answer late");

    property p_failsafe_mirror;
        @(posedge pclk) disable iff (!presetn)
        $past(failsafe_input_pin, 2) == $past(failsafe_input_pin, 3)
            |-> flags_b[BIT_FAILSAFE] == $past(failsafe_input_pin, 2);
    endproperty
    a_failsafe_mirror: assert property (p_failsafe_mirror) else $error("Failsafe wrong");

    property p_prog_done;
        @(posedge pclk) disable iff (!presetn)
        nvm_program_complete && prog_busy_q |=> prog_done_q && !prog_busy_q;
    endproperty
    a_prog_done: assert property (p_prog_done) else $error("Program done not set");

    property p_prog_mode;
        @(posedge pclk) disable iff (!presetn)
        nvm_program_start && !nvm_program_mode && !prog_busy_q
            |=> !prog_busy_q && $stable(prog_done_q);
    endproperty
    a_prog_mode: assert property (p_prog_mode) else $error("Start outside mode taken");

    property p_supply_low;
        @(posedge pclk) disable iff (!presetn)
        ##1 flags_b[BIT_SUPPLY_LOW] == $past(supply_below_threshold);
    endproperty
    a_supply_low: assert property (p_supply_low) else $error("Supply low bit wrong");

    property p_conv_done;
        @(posedge pclk) disable iff (!presetn)
        adc_conv_valid |=> conv_done_q && adc_result_q == $past(adc_conv_data);
    endproperty
    a_conv_done: assert property (p_conv_done) else $error("Conversion not flagged");

    property p_read_clear;
        @(posedge pclk) disable iff (!presetn)
        s_read_of_adc ##0 !adc_conv_valid |=> !conv_done_q;
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("Read did not clear flag");

    property p_diag_done;
        @(posedge pclk) disable iff (!presetn)
        diag_start && !diag_finish |=> !diag_done_q && diag_fault_q == '0;
    endproperty
    a_diag_done: assert property (p_diag_done) else $error("Diag start not clearing");

    property p_diag_fault;
        @(posedge pclk) disable iff (!presetn)
        diag_finish |=> diag_done_q
            && diag_fault_q == $past(diag_any);
    endproperty
    a_diag_fault: assert property (p_diag_fault) else $error("Diag faults wrong");

    property p_crc_fail;
        @(posedge pclk) disable iff (!presetn)
        crc_check_valid |=> flags_b[BIT_CRC_FAIL] == $past(crc_check_fail);
    endproperty
    a_crc_fail: assert property (p_crc_fail) else $error("CRC flag wrong");

    property p_diag_hi_zero;
        @(posedge pclk) disable iff (!presetn)
        psel && penable && pready && !pwrite && paddr == reg_addr(IDX_DIAG_HI)
            |-> prdata[DATA_W-1:4] == '0 && prdata[3:0] == $past(diag_hi_now);
    endproperty
    a_diag_hi_zero: assert property (p_diag_hi_zero) else $error("Diag high read wrong");

    property p_write_ignored;
        @(posedge pclk) disable iff (!presetn)
        wr_bank && !adc_conv_valid && !crc_ref_load && !diag_start && !diag_finish
            |=> $stable(adc_result_q) && $stable(crc_ref_q) && $stable(diag_fault_q);
    endproperty
    a_write_ignored: assert property (p_write_ignored) else $error("Write changed bank");

    property p_crc_ref_hold;
        @(posedge pclk) disable iff (!presetn)
        !crc_ref_load |=> $stable(crc_ref_q);
    endproperty
    a_crc_ref_hold: assert property (p_crc_ref_hold) else $error("CRC reference moved");

    property p_irq_level;
        @(posedge pclk) disable iff (!presetn)
        ##1 irq == $past(irq_pending);
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("Interrupt level wrong");

    property p_crc_ref_reset;
        @(posedge pclk) disable iff (!presetn)
        $rose(presetn) |-> crc_ref_q == CRC_REF_INIT;
    endproperty
    a_crc_ref_reset: assert property (p_crc_ref_reset) else $error("CRC reset wrong");

    // Set beats clear: an event in the clearing write's cycle must survive
    property p_irq_set_wins;
        @(posedge pclk) disable iff (!presetn)
        irq_evt != '0 |=> (irq_status_q & $past(irq_evt)) == $past(irq_evt);
    endproperty
    a_irq_set_wins: assert property (p_irq_set_wins) else $error("Event lost");

    property p_irq_clear;
        @(posedge pclk) disable iff (!presetn)
        wr_fire && pstrb[0] && paddr == reg_addr(IDX_IRQ_CLEAR) && irq_evt == '0
            |=> (irq_status_q & $past(clr_bits)) == '0;
    endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("Status not cleared");

    property p_prog_stray_done;
        @(posedge pclk) disable iff (!presetn)
        nvm_program_complete && !prog_busy_q && !prog_accept |=> $stable(prog_done_q);
    endproperty
    a_prog_stray_done: assert property (p_prog_stray_done) else $error("Stray done");

    property p_unmapped_err;
        @(posedge pclk) disable iff (!presetn)
        s_setup_access ##0 !rd_hit |=> pslverr && prdata == '0;
    endproperty
    a_unmapped_err: assert property (p_unmapped_err) else $error("Unmapped not refused");

    property p_supply_adc_load;
        @(posedge pclk) disable iff (!presetn)
        supply_adc_valid |=> supply_adc_q == $past(supply_adc_data);
    endproperty
    a_supply_adc_load: assert property (p_supply_adc_load) else $error("Supply lost");

    property p_adc_hold;
        @(posedge pclk) disable iff (!presetn)
        !adc_conv_valid |=> $stable(adc_result_q);
    endproperty
    a_adc_hold: assert property (p_adc_hold) else $error("ADC result moved");

    property p_bus_idle;
        @(posedge pclk) disable iff (!presetn)
        !(psel && penable) |=> !pready && !pslverr && prdata == '0;
    endproperty
    a_bus_idle: assert property (p_bus_idle) else $error("Answer outside access");
endmodule
`default_nettype wire

// ### testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import lsf_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0;
    logic [3:0] pstrb = 4'hF;
    logic [DATA_W-1:0] prdata;
    logic pready, pslverr, irq;
    logic failsafe = 1'b0, pmode = 1'b0, pstart = 1'b0, pdone = 1'b0, slow = 1'b0;
    logic sval = 1'b0, aval = 1'b0, dstart = 1'b0, dfin = 1'b0;
    logic cval = 1'b0, cfail = 1'b0, rload = 1'b0;
    logic [7:0] sdat = 8'h00, adat = 8'h00, rdat = 8'h00;
    logic [CH_NUM-1:0] dop = '0, dsh = '0, dss = '0;
    logic [33:0] expq[$];
    logic [33:0] ent;
    logic [7:0] fl = 8'h00;
    logic [IRQ_W-1:0] ist = '0;
    logic [31:0] r;
    logic [7:0] bank[6];
    logic [31:0] rst[6];
    int error_cnt = 0;
    int comparisons = 0;

    always #12.5 pclk = ~pclk;

    lsf_status_flags #(.ALT_SILICON(1'b0)) lsf_status_flags_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .failsafe_input_pin(failsafe), .nvm_program_mode(pmode),
        .nvm_program_start(pstart), .nvm_program_complete(pdone),
        .supply_below_threshold(slow), .supply_adc_valid(sval), .supply_adc_data(sdat),
        .adc_conv_valid(aval), .adc_conv_data(adat), .diag_start(dstart),
        .diag_finish(dfin), .diag_open(dop), .diag_short(dsh), .diag_single_short(dss),
        .crc_check_valid(cval), .crc_check_fail(cfail), .crc_ref_load(rload),
        .crc_ref_data(rdat), .irq(irq));

    task automatic end_sim;
        $display("Comparisons %0d, errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, m, g, e);
        end
    endtask

    // One transfer; expectation queued for the answer monitor
    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d,
                       input logic err);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= d;
        expq.push_back({~w, err, d});
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            chk(1'b0, 1'b1, "pready wait");
            end_sim();
        end else begin
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task automatic rd(input logic [7:0] idx, input logic [31:0] e);
        apb(1'b0, idx, e, 1'b0);
    endtask

    // Event pulses last exactly one edge
    task automatic pulse(input int k);
        @(posedge pclk);
        case (k)
            0: sval <= 1'b1;
            1: aval <= 1'b1;
            2: dstart <= 1'b1;
            3: dfin <= 1'b1;
            4: cval <= 1'b1;
            5: rload <= 1'b1;
            6: pstart <= 1'b1;
            default: pdone <= 1'b1;
        endcase
        @(posedge pclk);
        {sval, aval, dstart, dfin, cval, rload, pstart, pdone} <= '0;
    endtask

    // Answer monitor: read data only matters on reads
    always @(posedge pclk) begin
        if (presetn && psel && penable && pready === 1'b1) begin
            if (expq.size() == 0) begin
                chk(1'b0, 1'b1, "unexpected answer");
            end else begin
                ent = expq.pop_front();
                chk(pslverr, ent[32], "pslverr");
                if (ent[33]) begin
                    chk(prdata, ent[31:0], "prdata");
                end
            end
        end
    end

    initial begin
        repeat (100000) @(posedge pclk);
        chk(1'b0, 1'b1, "global timeout");
        end_sim();
    end

    initial begin
        bank = '{IDX_FLAGS_B, IDX_SUPPLY_ADC, IDX_ADC_RESULT,
                 IDX_DIAG_LO, IDX_DIAG_HI, IDX_CRC_REF};
        rst = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'hB3};
        void'($urandom(32'h9fe82511));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        // Second pass proves the writes of the first left nothing behind
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 6; i++) begin
                rd(bank[i], rst[i]);
                apb(1'b1, bank[i], $urandom, 1'b0);
            end
            rd(IDX_IRQ_STATUS, 32'h0);
            rd(IDX_IRQ_ENABLE, 32'h0);
            rd(IDX_IRQ_CLEAR, 32'h0);
            apb(1'b1, 8'h76, $urandom, 1'b1);
            apb(1'b0, 8'hFF, 32'h0, 1'b1);
        end
        for (int v = 1; v >= 0; v--) begin
            failsafe <= v[0];
            repeat (4) @(posedge pclk);
            fl[5] = v[0];
            rd(IDX_FLAGS_B, {24'h0, fl});
        end
        r = $urandom;
        sdat <= r[7:0];
        adat <= r[15:8];
        pulse(0);
        pulse(1);
        fl[2] = 1'b1;
        ist[IRQ_CONV] = 1'b1;
        rd(IDX_FLAGS_B, {24'h0, fl});
        rd(IDX_SUPPLY_ADC, {24'h0, r[7:0]});
        rd(IDX_ADC_RESULT, {24'h0, r[15:8]});
        fl[2] = 1'b0;
        rd(IDX_FLAGS_B, {24'h0, fl});
        rd(IDX_ADC_RESULT, {24'h0, r[15:8]});
        for (int v = 1; v >= 0; v--) begin
            slow <= v[0];
            repeat (3) @(posedge pclk);
            fl[3] = v[0];
            rd(IDX_FLAGS_B, {24'h0, fl});
        end
        ist[IRQ_SUPPLY] = 1'b1;
        // Each fault kind alone must reach the channel bits
        for (int k = 0; k < 3; k++) begin
            r = $urandom | 32'h801;
            {dss, dsh, dop} <= 36'(r[11:0]) << (12 * k);
            pulse(2);
            fl[1] = 1'b0;
            rd(IDX_FLAGS_B, {24'h0, fl});
            pulse(3);
            fl[1] = 1'b1;
            rd(IDX_FLAGS_B, {24'h0, fl});
            rd(IDX_DIAG_LO, {24'h0, r[7:0]});
            rd(IDX_DIAG_HI, {28'h0, r[11:8]});
        end
        ist[IRQ_DIAG] = 1'b1;
        // Outside programming mode the start must be ignored
        pulse(6);
        pulse(7);
        rd(IDX_FLAGS_B, {24'h0, fl});
        pmode <= 1'b1;
        pulse(6);
        rd(IDX_FLAGS_B, {24'h0, fl});
        pulse(7);
        fl[4] = 1'b1;
        ist[IRQ_PROG] = 1'b1;
        rd(IDX_FLAGS_B, {24'h0, fl});
        for (int v = 1; v >= 0; v--) begin
            cfail <= v[0];
            pulse(4);
            fl[0] = v[0];
            rd(IDX_FLAGS_B, {24'h0, fl});
        end
        ist[IRQ_CRC] = 1'b1;
        r = $urandom;
        rdat <= r[7:0];
        pulse(5);
        rd(IDX_CRC_REF, {24'h0, r[7:0]});
        rd(IDX_IRQ_STATUS, {27'h0, ist});
        apb(1'b1, IDX_IRQ_CLEAR, 32'h1F, 1'b0);
        rd(IDX_IRQ_STATUS, 32'h0);
        apb(1'b1, IDX_IRQ_ENABLE, 32'h1, 1'b0);
        rd(IDX_IRQ_ENABLE, 32'h1);
        // Lane 0 strobe low must drop the enable write
        pstrb <= 4'hE;
        apb(1'b1, IDX_IRQ_ENABLE, 32'h0, 1'b0);
        pstrb <= 4'hF;
        rd(IDX_IRQ_ENABLE, 32'h1);
        pulse(1);
        repeat (2) @(posedge pclk);
        #1 chk(irq, 1'b1, "irq raised");
        apb(1'b1, IDX_IRQ_ENABLE, 32'h0, 1'b0);
        repeat (2) @(posedge pclk);
        #1 chk(irq, 1'b0, "irq masked");
        apb(1'b1, IDX_IRQ_ENABLE, 32'h1, 1'b0);
        repeat (2) @(posedge pclk);
        #1 chk(irq, 1'b1, "irq unmasked");
        apb(1'b1, IDX_IRQ_CLEAR, 32'h1, 1'b0);
        repeat (2) @(posedge pclk);
        #1 chk(irq, 1'b0, "irq cleared");
        repeat (3) @(posedge pclk);
        chk(expq.size(), 32'h0, "answers missing");
        end_sim();
    end
endmodule
`default_nettype wire
